// File: rtl/keypad_pkg.sv
package keypad_pkg;

  // Matrix geometry and event store size
  localparam int ROWS       = 8;
  localparam int COLS       = 11;
  localparam int KEYS       = 88;
  localparam int IDS        = 96;
  localparam int FIFO_DEPTH = 16;

  // Register offsets
  localparam logic [7:0] REG_INT_STATUS   = 8'h01;
  localparam logic [7:0] REG_EVENT_STATUS = 8'h02;
  localparam logic [7:0] REG_FIFO_FIRST   = 8'h03;
  localparam logic [7:0] REG_FIFO_LAST    = 8'h12;
  localparam logic [7:0] REG_EVENT_CTRL   = 8'h3c;
  localparam logic [7:0] REG_SEL_A        = 8'h49;
  localparam logic [7:0] REG_SEL_B        = 8'h4a;
  localparam logic [7:0] REG_SEL_C        = 8'h4b;

  // Field positions
  localparam int CTRL_EVENT_IE = 0;
  localparam int CTRL_OVF_IE   = 1;
  localparam int CTRL_LOCK     = 2;
  localparam int CTRL_EXT_EN   = 3;
  localparam int INT_EVENT_BIT = 0;
  localparam int INT_OVF_BIT   = 1;
  localparam int STAT_LOCK_BIT = 5;

  // Reset values
  localparam logic [7:0] SEL_RESET  = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Serial slave address, value is arbitrary
  localparam logic [6:0] SLAVE_ADDR = 7'h2a;

  // Timing
  localparam int CLOCK_HZ      = 20_000_000;
  localparam int SETTLE_NS     = 1000;
  localparam int SETTLE_CYCLES = (SETTLE_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
  localparam int WAIT_US       = 10000;
  localparam int WAIT_CYCLES   = WAIT_US * (CLOCK_HZ / 1_000_000);

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_HIGH   = 3'b001,
    S_COL    = 3'b010,
    S_DECIDE = 3'b011,
    S_EMIT   = 3'b100,
    S_WAIT   = 3'b101
  } scan_state_t;

  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_ADDR = 3'b001,
    I_REG  = 3'b010,
    I_WR   = 3'b011,
    I_RD   = 3'b100
  } i2c_state_t;

endpackage : keypad_pkg

// File: rtl/keypad_scan_event_fifo.sv
`timescale 1ns/1ps
module keypad_scan_event_fifo #(
  parameter int WAIT_CYCLES = keypad_pkg::WAIT_CYCLES
) (
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  input  wire logic        ce_in,
  input  wire logic [7:0]  row_in,
  output logic      [10:0] col_out,
  output logic      [10:0] col_oe_out,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  output logic             int_n_out,
  input  wire logic        ext_event_valid_in,
  input  wire logic [7:0]  ext_event_in,
  output logic             ext_event_ready_out
);

  localparam logic [17:0] WAIT_LAST   = 18'(WAIT_CYCLES - 1);
  localparam logic [17:0] SETTLE_LAST = 18'(keypad_pkg::SETTLE_CYCLES - 1);
  localparam logic [3:0]  COL_LAST    = 4'(keypad_pkg::COLS - 1);
  localparam logic [6:0]  IDX_LAST    = 7'(keypad_pkg::IDS - 1);
  localparam logic [4:0]  FIFO_FULL   = 5'(keypad_pkg::FIFO_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0]  sel_a_q;
  logic [7:0]  sel_b_q;
  logic [2:0]  sel_c_q;
  logic [7:0]  ctrl_q;
  logic        event_int_q;
  logic        ovf_q;
  logic [7:0]  fifo_q [keypad_pkg::FIFO_DEPTH];
  logic [4:0]  count_q;

  keypad_pkg::scan_state_t scan_st_q;
  logic [17:0] tmr_q;
  logic [3:0]  col_idx_q;
  logic [6:0]  idx_q;
  logic [87:0] scan_q;
  logic [95:0] first_q;
  logic [95:0] stable_q;
  logic [95:0] chg_q;
  logic        go_idle_q;
  logic [10:0] col_q;

  keypad_pkg::i2c_state_t i2c_st_q;
  logic        scl_q;
  logic        sda_q;
  logic [3:0]  cnt_q;
  logic [7:0]  sh_q;
  logic [7:0]  rd_sh_q;
  logic        ack_q;
  logic        rw_q;
  logic        nack_q;
  logic [7:0]  ptr_q;
  logic        sda_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Serial register access decode

  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire start    = scl_in & scl_q & sda_q & ~sda_in;
  wire stop     = scl_in & scl_q & ~sda_q & sda_in;
  wire byte_end = scl_fall & ~ack_q & (cnt_q == 4'h8);
  wire in_fifo  = (ptr_q >= keypad_pkg::REG_FIFO_FIRST) && (ptr_q <= keypad_pkg::REG_FIFO_LAST);
  wire rd_load  = scl_fall & ack_q & (((i2c_st_q == keypad_pkg::I_ADDR) & rw_q) |
                                      ((i2c_st_q == keypad_pkg::I_RD) & ~nack_q));
  wire wr_stb   = byte_end & (i2c_st_q == keypad_pkg::I_WR);
  wire fifo_busy = (i2c_st_q != keypad_pkg::I_IDLE) & in_fifo;
  wire addr_hit  = (sh_q[7:1] == keypad_pkg::SLAVE_ADDR);
  wire fifo_empty = (count_q == 5'h00);
  wire fifo_full  = (count_q == FIFO_FULL);

  wire [7:0] head_entry = fifo_empty ? 8'h00 : fifo_q[0];
  wire [7:0] status_rd  = {2'h0, ctrl_q[keypad_pkg::CTRL_LOCK], count_q};
  wire [7:0] int_rd     = {6'h00, ovf_q, event_int_q};
  wire [7:0] rdata =
    in_fifo                                ? head_entry :
    (ptr_q == keypad_pkg::REG_INT_STATUS)   ? int_rd :
    (ptr_q == keypad_pkg::REG_EVENT_STATUS) ? status_rd :
    (ptr_q == keypad_pkg::REG_EVENT_CTRL)   ? ctrl_q :
    (ptr_q == keypad_pkg::REG_SEL_A)        ? sel_a_q :
    (ptr_q == keypad_pkg::REG_SEL_B)        ? sel_b_q :
    (ptr_q == keypad_pkg::REG_SEL_C)        ? {5'h00, sel_c_q} : 8'h00;

  wire pop = rd_load & in_fifo & ~fifo_empty;
  wire clr_event = wr_stb & (ptr_q == keypad_pkg::REG_INT_STATUS) & sh_q[keypad_pkg::INT_EVENT_BIT];
  wire clr_ovf   = wr_stb & (ptr_q == keypad_pkg::REG_INT_STATUS) & sh_q[keypad_pkg::INT_OVF_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Matrix sampling and decode

  wire [7:0]  row_en  = sel_a_q;
  wire [10:0] col_en  = {sel_c_q, sel_b_q};
  wire        row_low = |(~row_in & row_en);
  wire [95:0] sample;
  wire [7:0]  full_row;

  for (genvar r = 0; r < keypad_pkg::ROWS; r++)
  begin : g_row
    wire [10:0] keys = scan_q[r * keypad_pkg::COLS +: keypad_pkg::COLS];
    assign full_row[r] = row_en[r] & (|col_en) & (&(keys | ~col_en));
    assign sample[r * keypad_pkg::COLS +: keypad_pkg::COLS] = keys & {keypad_pkg::COLS{~full_row[r]}};
    assign sample[keypad_pkg::KEYS + r] = full_row[r];
  end

  wire [95:0] agree      = ~(sample ^ first_q);
  wire [95:0] chg_d      = agree & (sample ^ stable_q);
  wire [95:0] new_stable = stable_q ^ chg_d;

  ////////////////////////////////////////////////////////////////////////////
  // Event selection and store update

  wire       scan_req = (scan_st_q == keypad_pkg::S_EMIT) & chg_q[idx_q];
  wire [6:0] key_id   = 7'(idx_q + 7'h01);
  wire       ext_req  = ext_event_valid_in & ctrl_q[keypad_pkg::CTRL_EXT_EN] & ~scan_req;
  wire [7:0] ev_word  = scan_req ? {stable_q[idx_q], key_id} : ext_event_in;
  wire       ev_take  = (scan_req | ext_req) & ~fifo_busy;
  wire       locked   = ctrl_q[keypad_pkg::CTRL_LOCK];
  wire       push     = ev_take & ~locked & ~fifo_full;
  wire       ovf_set  = ev_take & ~locked & fifo_full;
  wire       emit_go  = ~(scan_req & fifo_busy);

  wire [10:0] col_d =
    (scan_st_q == keypad_pkg::S_COL)  ? ~(11'h001 << col_idx_q) :
    (scan_st_q == keypad_pkg::S_HIGH) ? 11'h7ff : 11'h000;

  assign col_out             = col_q;
  assign col_oe_out          = col_en;
  assign sda_out             = 1'b0;
  assign sda_oe_out          = sda_oe_q;
  assign ext_event_ready_out = ctrl_q[keypad_pkg::CTRL_EXT_EN] & ~scan_req & ~fifo_busy;
  assign int_n_out = ~((event_int_q & ctrl_q[keypad_pkg::CTRL_EVENT_IE]) |
                       (ovf_q & ctrl_q[keypad_pkg::CTRL_OVF_IE]));

  ////////////////////////////////////////////////////////////////////////////
  // Event store

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      count_q <= 5'h00;
      for (int i = 0; i < keypad_pkg::FIFO_DEPTH; i++) fifo_q[i] <= 8'h00;
    end
    else if (ce_in)
    begin
      if (pop)
      begin
        for (int i = 0; i < keypad_pkg::FIFO_DEPTH - 1; i++) fifo_q[i] <= fifo_q[i + 1];
        fifo_q[keypad_pkg::FIFO_DEPTH - 1] <= 8'h00;
        count_q <= count_q - 5'h01;
      end
      else if (push)
      begin
        fifo_q[count_q[3:0]] <= ev_word;
        count_q <= count_q + 5'h01;
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      event_int_q <= 1'b0;
      ovf_q       <= 1'b0;
    end
    else if (ce_in)
    begin
      event_int_q <= (event_int_q & ~clr_event) | push;
      ovf_q       <= (ovf_q & ~clr_ovf) | ovf_set;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sel_a_q <= keypad_pkg::SEL_RESET;
      sel_b_q <= keypad_pkg::SEL_RESET;
      sel_c_q <= keypad_pkg::SEL_RESET[2:0];
      ctrl_q  <= keypad_pkg::CTRL_RESET;
    end
    else if (ce_in && wr_stb)
    begin
      if (ptr_q == keypad_pkg::REG_SEL_A) sel_a_q <= sh_q;
      if (ptr_q == keypad_pkg::REG_SEL_B) sel_b_q <= sh_q;
      if (ptr_q == keypad_pkg::REG_SEL_C) sel_c_q <= sh_q[2:0];
      if (ptr_q == keypad_pkg::REG_EVENT_CTRL) ctrl_q <= sh_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Key scanner

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      scan_st_q <= keypad_pkg::S_IDLE;
      tmr_q     <= 18'h00000;
      col_idx_q <= 4'h0;
      idx_q     <= 7'h00;
      scan_q    <= '0;
      first_q   <= '0;
      stable_q  <= '0;
      chg_q     <= '0;
      go_idle_q <= 1'b0;
      col_q     <= 11'h000;
    end
    else if (ce_in)
    begin
      col_q <= col_d;
      tmr_q <= tmr_q + 18'h00001;
      unique case (scan_st_q)
        keypad_pkg::S_IDLE:
        begin
          tmr_q <= 18'h00000;
          if (row_low) scan_st_q <= keypad_pkg::S_HIGH;
        end
        keypad_pkg::S_HIGH:
        begin
          col_idx_q <= 4'h0;
          if (tmr_q == SETTLE_LAST)
          begin
            tmr_q     <= 18'h00000;
            scan_st_q <= keypad_pkg::S_COL;
          end
        end
        keypad_pkg::S_COL:
        begin
          if (tmr_q == SETTLE_LAST)
          begin
            tmr_q <= 18'h00000;
            for (int r = 0; r < keypad_pkg::ROWS; r++)
              scan_q[r * keypad_pkg::COLS + int'(col_idx_q)] <= ~row_in[r] & row_en[r] & col_en[col_idx_q];
            if (col_idx_q == COL_LAST) scan_st_q <= keypad_pkg::S_DECIDE;
            else col_idx_q <= col_idx_q + 4'h1;
          end
        end
        keypad_pkg::S_DECIDE:
        begin
          first_q   <= sample;
          stable_q  <= new_stable;
          chg_q     <= chg_d;
          go_idle_q <= ~(|sample) & ~(|new_stable);
          idx_q     <= 7'h00;
          scan_st_q <= keypad_pkg::S_EMIT;
        end
        keypad_pkg::S_EMIT:
        begin
          tmr_q <= 18'h00000;
          if (emit_go)
          begin
            idx_q <= idx_q + 7'h01;
            if (idx_q == IDX_LAST)
              scan_st_q <= go_idle_q ? keypad_pkg::S_IDLE : keypad_pkg::S_WAIT;
          end
        end
        keypad_pkg::S_WAIT:
        begin
          if (tmr_q == WAIT_LAST)
          begin
            tmr_q     <= 18'h00000;
            scan_st_q <= keypad_pkg::S_HIGH;
          end
        end
        default: scan_st_q <= keypad_pkg::S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial register slave

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      i2c_st_q <= keypad_pkg::I_IDLE;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      cnt_q    <= 4'h0;
      sh_q     <= 8'h00;
      rd_sh_q  <= 8'h00;
      ack_q    <= 1'b0;
      rw_q     <= 1'b0;
      nack_q   <= 1'b0;
      ptr_q    <= 8'h00;
      sda_oe_q <= 1'b0;
    end
    else if (ce_in)
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (start)
      begin
        i2c_st_q <= keypad_pkg::I_ADDR;
        cnt_q    <= 4'h0;
        ack_q    <= 1'b0;
        sda_oe_q <= 1'b0;
      end
      else if (stop)
      begin
        i2c_st_q <= keypad_pkg::I_IDLE;
        ack_q    <= 1'b0;
        sda_oe_q <= 1'b0;
      end
      else if (i2c_st_q != keypad_pkg::I_IDLE)
      begin
        if (scl_rise)
        begin
          if (ack_q) nack_q <= sda_in;
          else
          begin
            cnt_q <= cnt_q + 4'h1;
            if (i2c_st_q != keypad_pkg::I_RD) sh_q <= {sh_q[6:0], sda_in};
          end
        end
        else if (scl_fall && ack_q)
        begin
          ack_q    <= 1'b0;
          sda_oe_q <= 1'b0;
          if (i2c_st_q == keypad_pkg::I_ADDR)
            i2c_st_q <= rw_q ? keypad_pkg::I_RD : keypad_pkg::I_REG;
          else if (i2c_st_q == keypad_pkg::I_REG)
            i2c_st_q <= keypad_pkg::I_WR;
          else if (i2c_st_q == keypad_pkg::I_RD && nack_q)
            i2c_st_q <= keypad_pkg::I_IDLE;
          if (rd_load)
          begin
            rd_sh_q  <= {rdata[6:0], 1'b0};
            sda_oe_q <= ~rdata[7];
            ptr_q    <= ptr_q + 8'h01;
          end
        end
        else if (byte_end)
        begin
          cnt_q <= 4'h0;
          ack_q <= 1'b1;
          unique case (i2c_st_q)
            keypad_pkg::I_ADDR:
            begin
              rw_q     <= sh_q[0];
              sda_oe_q <= addr_hit;
              if (!addr_hit) i2c_st_q <= keypad_pkg::I_IDLE;
            end
            keypad_pkg::I_REG:
            begin
              ptr_q    <= sh_q;
              sda_oe_q <= 1'b1;
            end
            keypad_pkg::I_WR:
            begin
              ptr_q    <= ptr_q + 8'h01;
              sda_oe_q <= 1'b1;
            end
            keypad_pkg::I_RD: sda_oe_q <= 1'b0;
            default: i2c_st_q <= keypad_pkg::I_IDLE;
          endcase
        end
        else if (scl_fall && i2c_st_q == keypad_pkg::I_RD)
        begin
          sda_oe_q <= ~rd_sh_q[7];
          rd_sh_q  <= {rd_sh_q[6:0], 1'b0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  count_bound_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    count_q <= FIFO_FULL) else $error("event count above sixteen");

  pop_count_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (ce_in && pop) |=> (count_q == $past(count_q) - 5'h01) && (fifo_q[0] == $past(fifo_q[1])))
    else $error("head read did not shift and decrement");

  push_tail_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (ce_in && push) |=> (count_q == $past(count_q) + 5'h01) && (fifo_q[$past(count_q[3:0])] == $past(ev_word)))
    else $error("event not stored at tail");

  head_read_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (ce_in && rd_load && in_fifo && !fifo_empty) |=> (sda_oe_q == ~$past(fifo_q[0][7])))
    else $error("read did not return head entry");

  hold_off_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    fifo_busy |-> !push) else $error("store written during serial access");

  overflow_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (ce_in && ev_take && fifo_full && !locked) |=> ovf_q && (count_q == FIFO_FULL))
    else $error("overflow not flagged");

  lock_block_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (ce_in && locked && !clr_event) |=> $stable(count_q) || $past(pop))
    else $error("locked store changed count");

  event_int_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (ce_in && push) |=> event_int_q) else $error("event interrupt not raised");

  idle_cols_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (scan_st_q == keypad_pkg::S_IDLE) ##1 (scan_st_q == keypad_pkg::S_IDLE) |-> (col_out == 11'h000))
    else $error("columns not low while idle");

  key_id_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    scan_req |-> (key_id >= 7'h01) && (key_id <= 7'h60)) else $error("identifier out of range");

endmodule : keypad_scan_event_fifo

// File: bench/keypad_matrix_model.sv
`timescale 1ns/1ps
module keypad_matrix_model (
  input  wire logic [10:0] col_in,
  input  wire logic [10:0] col_oe_in,
  input  wire logic [87:0] key_in,
  input  wire logic [7:0]  gnd_row_in,
  output logic      [7:0]  row_out
);
  ////////////////////////////////////////////////////////////////////////////
  // passive matrix: rows pulled up, a closed switch only pulls a row low
  // through a column that is enabled and driven low; a grounded row is low always
  always_comb
  begin
    for (int r = 0; r < 8; r++)
    begin
      row_out[r] = ~gnd_row_in[r];
      for (int c = 0; c < 11; c++)
        if (key_in[r * 11 + c] && col_oe_in[c] && !col_in[c])
          row_out[r] = 1'b0;
    end
  end
endmodule : keypad_matrix_model

// File: bench/tb_keypad_scan_event_fifo.sv
`timescale 1ns/1ps
module tb_keypad_scan_event_fifo;
  logic        clock_in   = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        scl_q      = 1'b1;
  logic        sda_q      = 1'b1;
  logic        ev_valid_q = 1'b0;
  logic [7:0]  ev_data_q  = 8'h00;
  logic [87:0] keys_q     = '0;
  logic [7:0]  gnd_q      = 8'h00;
  logic [7:0]  row_w;
  logic [10:0] col_w;
  logic [10:0] col_oe_w;
  logic        sda_oe_w;
  logic        sda_out_w;
  logic        ce_q       = 1'b1;
  logic        int_n_out;
  logic        ready_w;
  logic [7:0]  rbuf [16];
  logic [7:0]  q [$];
  logic        lock_m = 1'b0;
  logic        ovf_m  = 1'b0;
  int          err_count = 0;
  int          n_tests   = 0;
  // Open drain: while enabled the device pulls the line low, since its data output is tied to zero
  wire logic   sda_line = sda_oe_w ? (sda_q & sda_out_w) : sda_q;
  localparam logic [7:0] WR_ADDR = {keypad_pkg::SLAVE_ADDR, 1'b0};

  always #25 clock_in = ~clock_in;

  keypad_scan_event_fifo #(.WAIT_CYCLES(50)) dut (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .ce_in(ce_q), .row_in(row_w),
    .col_out(col_w), .col_oe_out(col_oe_w), .scl_in(scl_q), .sda_in(sda_line),
    .sda_out(sda_out_w), .sda_oe_out(sda_oe_w), .int_n_out(int_n_out),
    .ext_event_valid_in(ev_valid_q), .ext_event_in(ev_data_q), .ext_event_ready_out(ready_w)
  );

  keypad_matrix_model pad (
    .col_in(col_w), .col_oe_in(col_oe_w), .key_in(keys_q), .gnd_row_in(gnd_q), .row_out(row_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  task wrap_up();
    if (err_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_byte

  task chk_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  ////////////////////////////////////////////////////////////////////////////
  // Serial host, clock high held four cycles and low five
  task sbit(input logic b, output logic r);
    sda_q <= b;
    repeat (4) @(posedge clock_in);
    scl_q <= 1'b1;
    repeat (4) @(posedge clock_in);
    r = sda_line;
    scl_q <= 1'b0;
    @(posedge clock_in);
  endtask : sbit

  task start();
    sda_q <= 1'b1;
    repeat (4) @(posedge clock_in);
    scl_q <= 1'b1;
    repeat (4) @(posedge clock_in);
    sda_q <= 1'b0;
    repeat (4) @(posedge clock_in);
    scl_q <= 1'b0;
    @(posedge clock_in);
  endtask : start

  task stop();
    sda_q <= 1'b0;
    repeat (4) @(posedge clock_in);
    scl_q <= 1'b1;
    repeat (4) @(posedge clock_in);
    sda_q <= 1'b1;
    repeat (4) @(posedge clock_in);
  endtask : stop

  task sbyte(input logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--)
      sbit(v[i], r);
    sbit(1'b1, r);
  endtask : sbyte

  task wr(input logic [7:0] ptr, input logic [7:0] v);
    start();
    sbyte(WR_ADDR);
    sbyte(ptr);
    sbyte(v);
    stop();
  endtask : wr

  task rd(input logic [7:0] ptr, input int n);
    logic r;
    start();
    sbyte(WR_ADDR);
    sbyte(ptr);
    start();
    sbyte(WR_ADDR | 8'h01);
    for (int i = 0; i < n; i++)
    begin
      for (int b = 7; b >= 0; b--)
        sbit(1'b1, rbuf[i][b]);
      sbit(i == n - 1, r);
    end
    stop();
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  // reference store: in order, nothing while locked, full drops new
  function automatic void mpush(input logic [7:0] v);
    if (lock_m)
      return;
    if (q.size() < keypad_pkg::FIFO_DEPTH)
      q.push_back(v);
    else
      ovf_m = 1'b1;
  endfunction : mpush

  // count first, then that many entries
  task drain();
    int n;
    n = q.size();
    rd(keypad_pkg::REG_EVENT_STATUS, 1);
    chk_byte("status", {2'b00, lock_m, n[4:0]}, rbuf[0]);
    if (n > 0)
      rd(keypad_pkg::REG_FIFO_FIRST, n);
    for (int i = 0; i < n; i++)
      chk_byte("entry", q.pop_front(), rbuf[i]);
  endtask : drain

  task wait_int();
    for (int k = 0; k < 3000 && int_n_out !== 1'b0; k++)
      @(posedge clock_in);
    chk_bit("event_irq", 1'b0, int_n_out);
  endtask : wait_int

  task key_event(input int idx, input bit gnd, input logic [7:0] id);
    for (int s = 1; s >= 0; s--)
    begin
      if (gnd)
        gnd_q[idx] <= s[0];
      else
        keys_q[idx] <= s[0];
      wait_int();
      mpush({s[0], id[6:0]});
      drain();
      wr(keypad_pkg::REG_INT_STATUS, 8'h01);
      chk_bit("irq_clear", 1'b1, int_n_out);
    end
  endtask : key_event

  task ext_push(input logic [7:0] v);
    ev_valid_q <= 1'b1;
    ev_data_q  <= v;
    for (int k = 0; k < 200; k++)
    begin
      @(posedge clock_in);
      if (ready_w === 1'b1)
        break;
    end
    ev_valid_q <= 1'b0;
    @(posedge clock_in);
    mpush(v);
  endtask : ext_push

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (60000) @(posedge clock_in);
    err_count++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(32'h594f988d));
    repeat (12) @(posedge clock_in);
    reset_n_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    wr(keypad_pkg::REG_SEL_A, 8'h0e);
    wr(keypad_pkg::REG_SEL_B, 8'he0);
    wr(keypad_pkg::REG_SEL_C, 8'hf8);
    rd(keypad_pkg::REG_SEL_A, 3);
    chk_byte("sel_a", 8'h0e, rbuf[0]);
    chk_byte("sel_b", 8'he0, rbuf[1]);
    chk_byte("sel_c", 8'h00, rbuf[2]);
    chk_byte("col_enable", 8'he0, col_oe_w[7:0]);
    chk_byte("col_idle", 8'h00, col_w[7:0]);
    chk_byte("col_enable_hi", 8'h00, {5'h00, col_oe_w[10:8]});
    chk_byte("col_idle_hi", 8'h00, {5'h00, col_w[10:8]});
    wr(keypad_pkg::REG_EVENT_CTRL, 8'h01);
    key_event(16, 1'b0, 8'd17);
    key_event(40, 1'b0, 8'd41);
    key_event(2, 1'b1, 8'd91);
    // Overflow with the extra source and both interrupts enabled
    wr(keypad_pkg::REG_EVENT_CTRL, 8'h0b);
    for (int i = 0; i < 17; i++)
      ext_push(8'($urandom()));
    rd(keypad_pkg::REG_INT_STATUS, 1);
    chk_byte("int_status", {6'b0, ovf_m, 1'b1}, rbuf[0]);
    // Clear the event flag so that only the overflow flag holds the line
    wr(keypad_pkg::REG_INT_STATUS, 8'h01);
    chk_bit("ovf_irq", 1'b0, int_n_out);
    drain();
    wr(keypad_pkg::REG_INT_STATUS, 8'h03);
    // Store held off while a transfer points into it
    start();
    sbyte(WR_ADDR);
    sbyte(keypad_pkg::REG_FIFO_FIRST);
    repeat (2) @(posedge clock_in);
    chk_bit("ready_held", 1'b0, ready_w);
    stop();
    chk_bit("ready_free", 1'b1, ready_w);
    ext_push(8'($urandom()));
    rd(keypad_pkg::REG_FIFO_LAST, 1);
    chk_byte("last_addr", q.pop_front(), rbuf[0]);
    wr(keypad_pkg::REG_INT_STATUS, 8'h03);
    // Clock enable low freezes the store, so an offered event is not taken
    ce_q       <= 1'b0;
    ev_valid_q <= 1'b1;
    ev_data_q  <= 8'($urandom());
    repeat (3) @(posedge clock_in);
    ev_valid_q <= 1'b0;
    ce_q       <= 1'b1;
    repeat (2) @(posedge clock_in);
    chk_bit("frozen_irq", 1'b1, int_n_out);
    wr(keypad_pkg::REG_EVENT_CTRL, 8'h0f);
    lock_m = 1'b1;
    ext_push(8'($urandom()));
    ext_push(8'($urandom()));
    chk_bit("locked_irq", 1'b1, int_n_out);
    drain();
    wrap_up();
  end
endmodule : tb_keypad_scan_event_fifo
